/* logic/eeiu_enclave_event_unit.v */
// Enclave event interaction unit: exits, access checks, status register
// Assumes single-cycle event pulses from core logic on clk
`timescale 1ns/10ps
`include "eeiu_regs.vh"

module eeiu_enclave_event_unit #(
  parameter THRESH_W = 8
) (
  // Clock, reset, enable
  input  wire                clk,
  input  wire                srst,
  input  wire                ce,
  // Processor mode
  input  wire                enclaveEnter,
  input  wire                enclaveLeave,
  input  wire                mgmtMode,
  input  wire                dualMonitor,
  input  wire                virtOn,
  input  wire                virtRoot,
  input  wire                bootProc,
  input  wire                safeModePresent,
  input  wire [THRESH_W-1:0] versionThreshold,
  // Platform events, one-cycle pulses except launchExitBusy, a level
  input  wire                mgmtIrq,
  input  wire                softRestart,
  input  wire                startupMsg,
  input  wire                launchEntry,
  input  wire                launchExitBusy,
  // Instruction issue
  input  wire                instValid,
  input  wire                instEnclave,
  input  wire                instSecureLaunch,
  input  wire                instOk,
  input  wire                moduleLaunch,
  input  wire [THRESH_W-1:0] moduleVersion,
  // Memory access check
  input  wire                accValid,
  input  wire                accImplicit,
  input  wire                accExplicit,
  input  wire                accFetch,
  input  wire                accInRange,
  input  wire                accOnApicPage,
  input  wire                accRedirect,
  input  wire                accPhysical,
  input  wire                accInPageCache,
  input  wire                accDma,
  input  wire                accReserved,
  // Status register read port
  input  wire                regRead,
  input  wire [31:0]         regAddr,
  output reg  [63:0]         regRdata,
  output reg                 regHit,
  // Results
  output reg                 insideEnclave,
  output reg                 asyncExit,
  output reg                 mgmtEntry,
  output reg                 mgmtVmExit,
  output reg                 restartVmExit,
  output reg                 powerOnInit,
  output reg                 fwInit,
  output reg  [1:0]          runState,
  output reg                 saveMapIntFlag,
  output reg                 exitReasonIntFlag,
  output reg                 guestIntrFlag,
  output reg  [2:0]          instFault,
  output reg  [2:0]          accFault,
  output reg                 dmaReject,
  output reg                 launchShutdown,
  output reg                 lockBit
);

  // ==========================================
  // Event decode
  wire inEnc       = insideEnclave;
  wire smiExit     = mgmtIrq & inEnc;
  wire rstBlocked  = virtOn & virtRoot;
  wire rstExit     = softRestart & inEnc & ~rstBlocked;
  wire launchExitE = launchEntry & inEnc;
  wire anyExit     = smiExit | rstExit | launchExitE;

  function [2:0] inst_check;
    input mm;
    input enc;
    input isEnc;
    input isLaunch;
    begin
      inst_check = `EEIU_FLT_NONE;
      if (mm && isEnc) begin
        inst_check = `EEIU_FLT_UNDEF;
      end
      if (enc && isLaunch) begin
        inst_check = `EEIU_FLT_UNDEF;
      end
    end
  endfunction

  // Status address decode, shared by hit and data
  function status_hit;
    input        rd;
    input [31:0] a;
    begin
      status_hit = rd && (a == `EEIU_STATUS_ADDR);
    end
  endfunction

  reg [2:0] next_accFault;
  always @* begin
    next_accFault = `EEIU_FLT_NONE;
    if (accValid) begin
      if (inEnc && accFetch && !accInRange) begin
        next_accFault = `EEIU_FLT_GPF;
      end else if (accImplicit) begin
        next_accFault = `EEIU_FLT_NONE;
      end else if (accExplicit && accOnApicPage) begin
        next_accFault = `EEIU_FLT_PAGE;
      end else if ((inEnc || instEnclave) && accRedirect) begin
        next_accFault = `EEIU_FLT_APIC_EXIT;
      end else if (accPhysical && accInPageCache) begin
        next_accFault = `EEIU_FLT_ABORT;
      end
    end
  end

  // ==========================================
  // State
  always @(posedge clk) begin
    if (srst) begin
      insideEnclave     <= 1'b0;
      asyncExit         <= 1'b0;
      mgmtEntry         <= 1'b0;
      mgmtVmExit        <= 1'b0;
      restartVmExit     <= 1'b0;
      powerOnInit       <= 1'b0;
      fwInit            <= 1'b0;
      runState          <= `EEIU_ST_RUN;
      saveMapIntFlag    <= 1'b0;
      exitReasonIntFlag <= 1'b0;
      guestIntrFlag     <= 1'b0;
      instFault         <= `EEIU_FLT_NONE;
      accFault          <= `EEIU_FLT_NONE;
      dmaReject         <= 1'b0;
      launchShutdown    <= 1'b0;
      lockBit           <= 1'b0;
      regRdata          <= 64'h0;
      regHit            <= 1'b0;
    end else if (ce) begin
      asyncExit     <= anyExit;
      mgmtEntry     <= 1'b0;
      mgmtVmExit    <= 1'b0;
      restartVmExit <= 1'b0;
      powerOnInit   <= 1'b0;
      fwInit        <= 1'b0;
      instFault     <= instValid ?
                       inst_check(mgmtMode, inEnc, instEnclave, instSecureLaunch) :
                       `EEIU_FLT_NONE;
      accFault      <= next_accFault;
      dmaReject     <= accDma & accReserved;
      if (anyExit || enclaveLeave) begin
        insideEnclave <= 1'b0;
      end else if (enclaveEnter) begin
        insideEnclave <= 1'b1;
      end
      // Non-enclave interrupt clears the three flags; set takes priority
      if (mgmtIrq) begin
        saveMapIntFlag    <= 1'b0;
        exitReasonIntFlag <= 1'b0;
        guestIntrFlag     <= 1'b0;
      end
      if (smiExit) begin
        if (!dualMonitor) begin
          mgmtEntry      <= 1'b1;
          saveMapIntFlag <= 1'b1;
        end else begin
          mgmtVmExit        <= 1'b1;
          exitReasonIntFlag <= 1'b1;
          guestIntrFlag     <= 1'b1;
        end
      end
      if (rstExit) begin
        if (!virtOn) begin
          powerOnInit <= 1'b1;
          fwInit      <= bootProc;
          runState    <= bootProc ? `EEIU_ST_RUN : `EEIU_ST_WAIT_STARTUP;
        end else begin
          restartVmExit     <= 1'b1;
          exitReasonIntFlag <= 1'b1;
        end
      end else begin
        case (runState)
          `EEIU_ST_RUN: begin
            if (launchExitE) begin
              runState <= `EEIU_ST_WAIT_STARTUP;
            end else if (inEnc && launchExitBusy) begin
              runState <= `EEIU_ST_PAUSED;
            end
          end
          `EEIU_ST_WAIT_STARTUP: begin
            if (startupMsg && !inEnc) begin
              runState <= `EEIU_ST_RUN;
            end
          end
          `EEIU_ST_PAUSED: begin
            if (!launchExitBusy) begin
              runState <= `EEIU_ST_RUN;
            end
          end
          default: begin
            runState <= `EEIU_ST_RUN;
          end
        endcase
      end
      // no write path, only reset clears
      if (instValid && instEnclave && instOk &&
          inst_check(mgmtMode, inEnc, instEnclave, instSecureLaunch) == `EEIU_FLT_NONE) begin
        lockBit <= 1'b1;
      end
      launchShutdown <= moduleLaunch & lockBit & safeModePresent &
                        (moduleVersion < versionThreshold);
      regHit   <= status_hit(regRead, regAddr);
      regRdata <= 64'h0;
      if (status_hit(regRead, regAddr)) begin
        regRdata[`EEIU_LOCK_BIT] <= lockBit;
        if (safeModePresent) begin
          regRdata[`EEIU_THRESH_MSB:`EEIU_THRESH_LSB] <= versionThreshold[7:0];
        end
      end
    end
  end

endmodule

/* pkg/eeiu_regs.vh */
// Constants for the enclave event interaction unit
// Assumes inclusion by the single design file under logic/
//
// What this block does
// - Enclave instructions in management mode fault undefined
// - Management interrupt, no dual monitor: exit, mark save map
// - Dual monitor: exit, flag exit reason and interruptibility
// - Saved interrupted flag set only by enclave exits
// - Restart outside virtualization: exit, reset, boot or wait
// - Restart in root operation is blocked
// - Restart in non-root: exit, VM exit flagged
// - Startup message inside enclave is discarded
// - Unblocked restart clears enclave mode; outside virtualization it also sets run state
// - DMA to reserved processor memory is rejected
// - Implicit cached accesses skip access page check
// - Explicit enclave access on access page page-faults
// - Redirected enclave access becomes access VM exit
// - Physical accesses reaching page cache get abort-page
// - Fetch range check precedes access page check
// - Secure launch leaves fault undefined inside enclave
// - Responder in enclave at launch entry: exit, wait
// - Responder pauses during launch exit, then resumes
// - Read-only status register at 500h, lock and threshold
// - Successful enclave instruction sets lock, gates modules
`ifndef EEIU_REGS_VH
`define EEIU_REGS_VH

// ==========================================
// Register map
`define EEIU_STATUS_ADDR       32'h0000_0500
`define EEIU_LOCK_BIT          0
`define EEIU_THRESH_LSB        16
`define EEIU_THRESH_MSB        23
`define EEIU_SAVE_MAP_OFFSET   16'h7ee0
`define EEIU_SAVE_MAP_INT_BIT  1

// ==========================================
// Fault codes
`define EEIU_FLT_NONE          3'h0
`define EEIU_FLT_UNDEF         3'h1
`define EEIU_FLT_GPF           3'h2
`define EEIU_FLT_PAGE          3'h3
`define EEIU_FLT_ABORT         3'h4
`define EEIU_FLT_APIC_EXIT     3'h5

// ==========================================
// Processor run states
`define EEIU_ST_RUN            2'h0
`define EEIU_ST_WAIT_STARTUP   2'h1
`define EEIU_ST_PAUSED         2'h2

`endif

/* verif/eeiu_sva.sv */
// Port assertions for the enclave event unit
// Assumes a bind onto eeiu_enclave_event_unit, one clock
`timescale 1ns/10ps
module eeiu_sva (
  // Clock, reset, enable
  input wire        clk, srst, ce,
  // Requests
  input wire        mgmtMode, dualMonitor, virtOn, virtRoot, mgmtIrq, softRestart,
  input wire        startupMsg, instValid, instEnclave, accValid, accFetch, accInRange,
  input wire        accDma, accReserved, regRead,
  input wire [31:0] regAddr,
  // Results
  input wire [63:0] regRdata,
  input wire [2:0]  instFault, accFault,
  input wire [1:0]  runState,
  input wire        regHit, insideEnclave, asyncExit, mgmtEntry, mgmtVmExit, powerOnInit,
  input wire        saveMapIntFlag, exitReasonIntFlag, guestIntrFlag, dmaReject, lockBit
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_mgmt_undef: assert property (ce && instValid && instEnclave && mgmtMode |=> instFault == 3'h1)
    else $error("management mode instruction not faulted");
  a_smi_exit: assert property (ce && mgmtIrq && insideEnclave && !dualMonitor
    |=> asyncExit && mgmtEntry && saveMapIntFlag && !insideEnclave)
    else $error("interrupt exit wrong");
  a_dual_exit: assert property (ce && mgmtIrq && insideEnclave && dualMonitor
    |=> asyncExit && mgmtVmExit && exitReasonIntFlag && guestIntrFlag)
    else $error("dual monitor exit wrong");
  a_root_block: assert property (ce && softRestart && insideEnclave && virtOn && virtRoot
    |=> !asyncExit && !powerOnInit)
    else $error("restart in root not blocked");
  a_startup_drop: assert property (ce && startupMsg && insideEnclave |=> $stable(runState))
    else $error("startup inside enclave not dropped");
  a_dma_reject: assert property (ce && accDma && accReserved |=> dmaReject)
    else $error("reserved dma not rejected");
  a_fetch_range: assert property (ce && accValid && insideEnclave && accFetch && !accInRange
    |=> accFault == 3'h2)
    else $error("fetch outside range not gpf");
  a_status_read: assert property (ce && regRead && regAddr == 32'h500
    |=> regHit && regRdata[15:1] == 15'h0 && regRdata[63:24] == 40'h0
    && regRdata[0] == $past(lockBit))
    else $error("status read wrong");
  a_lock_hold: assert property (lockBit |=> lockBit)
    else $error("lock dropped without reset");
endmodule

/* verif/eeiu_sw_partner.sv */
// Software side: reads status before a module launch
// Assumes read data answers one edge after the request
`timescale 1ns/10ps
module eeiu_sw_partner (
  // Bench control
  input  wire        clk,
  input  wire        go,
  input  wire [31:0] addr,
  input  wire [7:0]  moduleVersion,
  // Unit read port
  input  wire [63:0] regRdata,
  output wire        regRead,
  output wire [31:0] regAddr,
  // Decision
  output reg  [63:0] seen = 64'h0,
  output wire        refuse
);
  reg pend = 1'b0;
  assign regRead = go;
  // Idle address inverted so nothing leans on a stale value
  assign regAddr = go ? addr : ~addr;
  always @(posedge clk) begin
    pend <= go;
    if (pend)
      seen <= regRdata;
  end
  assign refuse = seen[0] & (seen[23:16] > moduleVersion);
endmodule

/* verif/enclave_event_interaction_unit_tb_top.sv */
// Self-checking bench for the enclave event unit
// Assumes checker and partner files compiled first
`timescale 1ns/10ps
module enclave_event_interaction_unit_tb_top;
  reg clk=0,srst=1,ce=1,enclaveEnter=0,enclaveLeave=0,mgmtMode=0,dualMonitor=0,virtOn=0;
  reg virtRoot=0,bootProc=0,safeModePresent=0,mgmtIrq=0,softRestart=0,startupMsg=0,go=0;
  reg launchEntry=0,launchExitBusy=0,instValid=0,instEnclave=0,instSecureLaunch=0,instOk=0;
  reg moduleLaunch=0,accValid=0,accDma=0,accReserved=0;
  reg [7:0] versionThreshold=0,moduleVersion=0,av=0;
  reg [31:0] addr=0;
  reg [6:0] e;
  reg [10:0] tab [0:4];
  wire accImplicit=av[7],accExplicit=av[6],accFetch=av[5],accInRange=av[4];
  wire accOnApicPage=av[3],accRedirect=av[2],accPhysical=av[1],accInPageCache=av[0];
  wire [63:0] regRdata,seen;
  wire [31:0] regAddr;
  wire [2:0] instFault,accFault;
  wire [1:0] runState;
  wire regRead,regHit,insideEnclave,asyncExit,mgmtEntry,mgmtVmExit,restartVmExit,powerOnInit;
  wire fwInit,saveMapIntFlag,exitReasonIntFlag,guestIntrFlag,dmaReject,launchShutdown,lockBit;
  wire refuse;
  wire [6:0] rsOut={asyncExit,powerOnInit,fwInit,restartVmExit,runState,insideEnclave};
  integer failures=0,checks=0,lockM=0,i,j,k,r;
  eeiu_enclave_event_unit u_eeiu_enclave_event_unit (.*);
  eeiu_sw_partner u_eeiu_sw_partner (.*);
  always #12.5 clk = ~clk;
  task step; begin @(posedge clk); #1; end endtask
  task check(input [8*10:1] n, input [63:0] x, input [63:0] s); begin
    checks = checks + 1;
    if (x !== s) begin
      failures = failures + 1;
      $display("FAIL %0s exp %h got %h", n, x, s);
    end
  end endtask
  task rd(input [31:0] a, input h); begin
    addr = a; go = 1; step; go = 0; check("hit", h, regHit); step;
  end endtask
  task enter; begin enclaveEnter = 1; step; enclaveEnter = 0; end endtask
  task pulseStart; begin startupMsg = 1; step; startupMsg = 0; end endtask
  task conclude; begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end endtask
  initial begin #200000; failures = failures + 1; conclude; end
  initial begin
    r = $urandom(32'h8faf0307);
    versionThreshold = 8'h02 + $urandom % 8'hfd;
    tab[0]=11'h088; tab[1]=11'h358; tab[2]=11'h504; tab[3]=11'h403; tab[4]=11'h228;
    repeat (8) @(posedge clk);
    #1 srst = 0;
    for (i = 0; i < 2; i = i + 1) begin
      safeModePresent = i; rd(32'h500, 1);
      check("status", {40'h0, i ? versionThreshold : 8'h0, 15'h0, lockM[0]}, seen);
    end
    rd(32'h501, 0); check("unmapped", 64'h0, seen);
    $display("test status done");
    enter; mgmtIrq = 1; step; mgmtIrq = 0;
    check("smi", 4'b1110, {asyncExit, mgmtEntry, saveMapIntFlag, insideEnclave});
    dualMonitor = 1; enter; mgmtIrq = 1; step; mgmtIrq = 0; dualMonitor = 0;
    check("dual", 5'h1e, {asyncExit, mgmtVmExit, exitReasonIntFlag, guestIntrFlag, insideEnclave});
    mgmtIrq = 1; step; mgmtIrq = 0;
    check("flagclear", 3'h0, {saveMapIntFlag, exitReasonIntFlag, guestIntrFlag});
    for (j = 0; j < 4; j = j + 1) begin
      bootProc = (j == 0); virtOn = j[1]; virtRoot = (j == 2); enter;
      softRestart = 1; step; softRestart = 0;
      e = {j != 2, j < 2, j == 0, j == 3, (j == 1) ? 2'h1 : 2'h0, j == 2};
      check("restart", e, rsOut);
      if (insideEnclave === 1'b1) begin enclaveLeave = 1; step; enclaveLeave = 0; end
      // bench as software restarts clean after restart
      pulseStart;
    end
    enter; pulseStart; check("startup", 3'b001, {runState, insideEnclave});
    launchEntry = 1; step; launchEntry = 0;
    check("launch", 3'b101, {asyncExit, runState});
    enter; pulseStart; check("startupw", 3'b011, {runState, insideEnclave});
    enclaveLeave = 1; step; enclaveLeave = 0;
    pulseStart;
    enter; launchExitBusy = 1; step;
    check("pause", 2'h2, runState);
    launchExitBusy = 0; step;
    check("resume", 2'h0, runState);
    $display("test events done");
    mgmtMode = 1; instValid = 1; instEnclave = 1; step; mgmtMode = 0;
    check("mgmtinst", 3'h1, instFault);
    enter; instEnclave = 0; instSecureLaunch = 1; step; instSecureLaunch = 0;
    check("secinst", 3'h1, instFault);
    instEnclave = 1; instOk = 1; step; {instValid, instEnclave, instOk} = 3'h0; lockM = 1;
    check("lock", 1'b1, lockBit);
    rd(32'h500, 1); check("status", {40'h0, versionThreshold, 15'h0, 1'b1}, seen);
    for (k = 0; k < 2; k = k + 1) begin
      moduleVersion = versionThreshold - 8'h1 + k[7:0]; moduleLaunch = 1; step; moduleLaunch = 0;
      check("shutdown", k == 0, launchShutdown);
      check("refuse", k == 0, refuse);
    end
    for (k = 0; k < 5; k = k + 1) begin
      av = tab[k][7:0]; accValid = 1; step; accValid = 0;
      check("access", tab[k][10:8], accFault);
    end
    for (k = 0; k < 2; k = k + 1) begin
      accDma = 1; accReserved = k[0]; step; accDma = 0;
      check("dma", k[0], dmaReject);
    end
    srst = 1; step; srst = 0; check("lockreset", 1'b0, lockBit);
    $display("test access and lock done");
    conclude;
  end
endmodule
bind eeiu_enclave_event_unit eeiu_sva u_eeiu_sva (.*);
